// *** core/dpt_pkg.sv ***
// Shared constants, types and helpers of the DMA page table translator
//
// Behaviour
// [R01] Software places every page table as a 4 kB block on a 4 kB boundary.
// [R02] Each table entry is the physical base of one contiguous 4 kB page.
// [R03] With 64-bit addressing an entry is 8 bytes, so a table has 512.
// [R04] One table maps a buffer of at most 2 MB and no more.
// [R05] Each packet names which of the 12 DMA channels produced it.
// [R06] The table is picked from the channel number and the buffer number.
// [R07] Eight table base pointers are held per channel, one per buffer.
// [R08] A channel with only one buffer enabled still translates correctly.
// [R09] Software should give each channel at least two buffers.
// [R10] The buffer number is a field inside the packet's logical address.
// [R11] A buffer change reloads the whole set of prefetched entries.
// [R12] Sixteen virtual channel numbers are accepted, not only the twelve.
// [R13] Logical addresses are 32 bits, physical addresses 64 bits.
// [R14] A mode input makes the translator give 32-bit physical addresses.
// [R15] Eight table entries are fetched ahead in one burst.
// [R16] The translated packet keeps its traffic class for the link core.
// [R17] The low 12 address bits pass unchanged as the page offset.
package dpt_pkg;

  // ==========================================================
  // Widths and counts
  localparam int VCHAN_W = 4;
  localparam int NUM_VCHAN = 16;
  localparam int NUM_PHYS_CHAN = 12;
  localparam int BUF_W = 3;
  localparam int NUM_BUF = 8;
  localparam int LADDR_W = 32;
  localparam int PADDR_W = 64;
  localparam int TC_W = 3;
  localparam int DATA_W = 64;
  localparam int PAGE_W = 12;
  localparam int BASE_W = PADDR_W - PAGE_W;
  localparam int IDX_W = 9;
  localparam int PF_W = 3;
  localparam int PREFETCH = 8;
  localparam int GROUP_W = IDX_W - PF_W;

  // ==========================================================
  // Field positions in the logical address
  localparam int IDX_LSB = 12;
  localparam int BUF_LSB = 21;

  // ==========================================================
  // Reset values and fixed figures
  localparam logic [PF_W-1:0] PF_LAST = 3'h7;
  localparam logic [PF_W-1:0] FILL_RST = 3'h0;
  localparam logic [5:0] BURST_ALIGN = 6'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [VCHAN_W-1:0] vchan;
    logic [TC_W-1:0] tc;
    logic [LADDR_W-1:0] laddr;
    logic [DATA_W-1:0] data;
  } dpt_pkt_t;

  typedef struct packed {
    logic [TC_W-1:0] tc;
    logic [PADDR_W-1:0] paddr;
    logic [DATA_W-1:0] data;
  } dpt_out_t;

  typedef struct packed {
    logic [VCHAN_W-1:0] vchan;
    logic [BUF_W-1:0] buf_no;
    logic [GROUP_W-1:0] group;
  } dpt_tag_t;

  // ==========================================================
  // Address field helpers
  function automatic logic [IDX_W-1:0] page_index(
    input logic [LADDR_W-1:0] laddr);
    page_index = laddr[IDX_LSB +: IDX_W];
  endfunction

  function automatic logic [BUF_W-1:0] buf_field(
    input logic [LADDR_W-1:0] laddr);
    buf_field = laddr[BUF_LSB +: BUF_W];
  endfunction

endpackage

// *** core/dpt_skid.sv ***
// Two-entry skid buffer with registered outputs
`timescale 1ns/1ps
module dpt_skid #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  // ==========================================================
  // Checks
  if (W < 1) begin : g_bad_w
    $error("dpt_skid width must be positive");
  end

  logic skid_valid;
  logic [W-1:0] skid_data;
  logic next_out_valid;
  logic [W-1:0] next_out_data;
  logic next_skid_valid;
  logic [W-1:0] next_skid_data;

  // Ready depends only on a flop, so the source sees no path from sink
  assign in_ready = !skid_valid;

  // ==========================================================
  // Next state
  always_comb begin
    next_out_valid = out_valid;
    next_out_data = out_data;
    next_skid_valid = skid_valid;
    next_skid_data = skid_data;
    if (out_ready || !out_valid) begin
      if (skid_valid) begin
        next_out_valid = 1'b1;
        next_out_data = skid_data;
        next_skid_valid = 1'b0;
      end else begin
        next_out_valid = in_valid;
        next_out_data = in_valid ? in_data : out_data;
      end
    end else if (in_valid && in_ready) begin
      // Sink stalled: park the word rather than drop it
      next_skid_valid = 1'b1;
      next_skid_data = in_data;
    end
  end

  // Registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
      skid_valid <= 1'b0;
      skid_data <= '0;
    end else begin
      out_valid <= next_out_valid;
      out_data <= next_out_data;
      skid_valid <= next_skid_valid;
      skid_data <= next_skid_data;
    end
  end

endmodule

// *** core/dpt_base_table.sv ***
// Table base pointer store, one pointer per virtual channel and buffer
`timescale 1ns/1ps
module dpt_base_table #(
  parameter int CHANS = 16,
  parameter int BUFS = 8,
  parameter int W = 52
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [$clog2(CHANS*BUFS)-1:0] wr_sel,
  input wire logic [W-1:0] wr_base,
  input wire logic [$clog2(CHANS*BUFS)-1:0] rd_sel,
  output logic [W-1:0] rd_base
);

  // ==========================================================
  // Checks
  if (CHANS < 1 || BUFS < 1 || W < 1) begin : g_bad_size
    $error("dpt_base_table sizes must be positive");
  end

  // Pointers are stored without their low 12 bits: tables are page aligned
  logic [W-1:0] mem [CHANS*BUFS];

  // Write port; no reset, software loads every pointer it enables
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_sel] <= wr_base;
    end
  end

  // Read port
  assign rd_base = mem[rd_sel];

endmodule

// *** core/dpt_translator.sv ***
// DMA page table translator: logical to physical address mapping
`timescale 1ns/1ps
module dpt_translator #(
  parameter int NUM_VCHAN = dpt_pkg::NUM_VCHAN,
  parameter int NUM_BUF = dpt_pkg::NUM_BUF
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire dpt_pkg::dpt_pkt_t in_pkt,
  output logic in_ready,
  output logic out_valid,
  output dpt_pkg::dpt_out_t out_pkt,
  input wire logic out_ready,
  input wire logic cfg_wr,
  input wire logic [dpt_pkg::VCHAN_W-1:0] cfg_vchan,
  input wire logic [dpt_pkg::BUF_W-1:0] cfg_buf,
  input wire logic [dpt_pkg::BASE_W-1:0] cfg_base,
  input wire logic addr32_mode,
  output logic rd_req_valid,
  output logic [dpt_pkg::PADDR_W-1:0] rd_req_addr,
  input wire logic rd_req_ready,
  input wire logic rd_rsp_valid,
  input wire logic [dpt_pkg::PADDR_W-1:0] rd_rsp_data,
  output logic fill_busy
);

  // ==========================================================
  // Checks
  if (NUM_VCHAN != 2 ** dpt_pkg::VCHAN_W) begin : g_bad_vchan
    $error("NUM_VCHAN must match the channel field width");
  end
  if (NUM_BUF != 2 ** dpt_pkg::BUF_W) begin : g_bad_buf
    $error("NUM_BUF must match the buffer field width");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_REQ,
    ST_FILL,
    ST_SEND
  } dpt_state_t;

  // ==========================================================
  // Declarations
  dpt_state_t state, next_state;
  dpt_pkg::dpt_pkt_t hold, next_hold;
  dpt_pkg::dpt_tag_t tag_q, next_tag_q, cur_tag;
  logic tag_valid, next_tag_valid;
  logic next_in_ready;
  logic next_rd_req_valid;
  logic [dpt_pkg::PADDR_W-1:0] next_rd_req_addr, fetch_addr, phys;
  logic [dpt_pkg::PF_W-1:0] fill_cnt, next_fill_cnt;
  logic [dpt_pkg::BASE_W-1:0] pte [dpt_pkg::PREFETCH];
  logic [dpt_pkg::BASE_W-1:0] next_pte [dpt_pkg::PREFETCH];
  logic [dpt_pkg::BASE_W-1:0] tbl_base;
  logic [dpt_pkg::IDX_W-1:0] idx;
  logic [dpt_pkg::BUF_W-1:0] buf_no;
  logic hit;
  logic bf_in_valid, bf_in_ready;
  dpt_pkg::dpt_out_t bf_in_data;

  // ==========================================================
  // Table base pointers, chosen by virtual channel and buffer
  dpt_base_table #(
    .CHANS(NUM_VCHAN),
    .BUFS(NUM_BUF),
    .W(dpt_pkg::BASE_W)
  ) u_base (
    .sys_clk(sys_clk),
    .wr_en(cfg_wr),
    .wr_sel({cfg_vchan, cfg_buf}),
    .wr_base(cfg_base),
    .rd_sel({hold.vchan, buf_no}), // R06
    .rd_base(tbl_base)
  );

  // ==========================================================
  // Address decode of the held packet
  always_comb begin
    // Buffer number rides in the logical address; one buffer means 0
    buf_no = dpt_pkg::buf_field(hold.laddr); // R10 R08
    // Nine index bits: 512 entries of 8 bytes, 2 MB per table
    idx = dpt_pkg::page_index(hold.laddr); // R03 R04
    cur_tag.vchan = hold.vchan; // R05 R12
    cur_tag.buf_no = buf_no; // R07
    cur_tag.group = idx[dpt_pkg::IDX_W-1:dpt_pkg::PF_W];
    hit = tag_valid && (tag_q == cur_tag);
    // Burst of eight entries, 64 bytes, inside the page-aligned table
    fetch_addr = {tbl_base, cur_tag.group, dpt_pkg::BURST_ALIGN}; // R15
    // Entry gives the page base, offset bits pass straight through
    phys = {pte[idx[dpt_pkg::PF_W-1:0]],
            hold.laddr[dpt_pkg::PAGE_W-1:0]}; // R02 R17 R13
    if (addr32_mode) begin
      // Legacy hosts see no address above 4 GB
      fetch_addr[63:32] = '0; // R14
      phys[63:32] = '0; // R14
    end
  end

  // Buffer feed; the link core routes by the class kept here
  always_comb begin
    bf_in_valid = (state == ST_SEND);
    bf_in_data.tc = hold.tc; // R16
    bf_in_data.paddr = phys;
    bf_in_data.data = hold.data;
  end

  // ==========================================================
  // Control next state
  always_comb begin
    next_state = state;
    next_hold = hold;
    next_tag_q = tag_q;
    next_tag_valid = tag_valid;
    next_in_ready = in_ready;
    next_rd_req_valid = rd_req_valid;
    next_rd_req_addr = rd_req_addr;
    next_fill_cnt = fill_cnt;
    for (int i = 0; i < dpt_pkg::PREFETCH; i++) begin
      next_pte[i] = pte[i];
    end
    case (state)
      ST_IDLE: begin
        if (in_valid && in_ready) begin
          next_hold = in_pkt;
          next_in_ready = 1'b0;
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (hit) begin
          next_state = ST_SEND; // R07
        end else begin
          // Different buffer, channel or group: drop the whole set
          next_tag_valid = 1'b0; // R11
          next_tag_q = cur_tag;
          next_rd_req_valid = 1'b1;
          next_rd_req_addr = fetch_addr; // R06
          next_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (rd_req_ready) begin
          next_rd_req_valid = 1'b0;
          next_fill_cnt = dpt_pkg::FILL_RST;
          next_state = ST_FILL;
        end
      end
      ST_FILL: begin
        if (rd_rsp_valid) begin
          // Entry words arrive in index order; low 12 bits are unused
          next_pte[fill_cnt] =
            rd_rsp_data[dpt_pkg::PADDR_W-1:dpt_pkg::PAGE_W]; // R02
          next_fill_cnt = dpt_pkg::PF_W'(fill_cnt + 3'h1);
          if (fill_cnt == dpt_pkg::PF_LAST) begin
            next_tag_valid = 1'b1; // R15
            next_state = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        if (bf_in_ready) begin
          next_in_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_in_ready = 1'b1;
        next_rd_req_valid = 1'b0;
        next_tag_valid = 1'b0;
      end
    endcase
    // A new base pointer may change any mapping; a fill or a send in flight wins
    if (cfg_wr && state != ST_FILL && state != ST_SEND) begin
      next_tag_valid = 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      hold <= '0;
      tag_q <= '0;
      tag_valid <= 1'b0;
      in_ready <= 1'b1;
      rd_req_valid <= 1'b0;
      rd_req_addr <= '0;
      fill_cnt <= dpt_pkg::FILL_RST;
      fill_busy <= 1'b0;
    end else begin
      state <= next_state;
      hold <= next_hold;
      tag_q <= next_tag_q;
      tag_valid <= next_tag_valid;
      in_ready <= next_in_ready;
      rd_req_valid <= next_rd_req_valid;
      rd_req_addr <= next_rd_req_addr;
      fill_cnt <= next_fill_cnt;
      fill_busy <= (next_state == ST_REQ) || (next_state == ST_FILL);
    end
  end

  // Prefetched entries need no reset: tag_valid guards them
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < dpt_pkg::PREFETCH; i++) begin
      pte[i] <= next_pte[i];
    end
  end

  // ==========================================================
  // Output buffer; a stalled link core loses no packet
  dpt_skid #(
    .W($bits(dpt_pkg::dpt_out_t))
  ) u_skid (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(bf_in_valid),
    .in_data(bf_in_data),
    .in_ready(bf_in_ready),
    .out_valid(out_valid),
    .out_data(out_pkt),
    .out_ready(out_ready)
  );

  // ==========================================================
  // Assertions
  page_offset_a: assert property ( // R17
    @(posedge sys_clk) disable iff (!arst_n)
    bf_in_valid |-> bf_in_data.paddr[11:0] == hold.laddr[11:0])
    else $error("page offset altered");

  entry_base_a: assert property ( // R02
    @(posedge sys_clk) disable iff (!arst_n)
    bf_in_valid && !addr32_mode |->
      bf_in_data.paddr[63:12] == pte[hold.laddr[14:12]])
    else $error("physical page not from prefetched entry");

  narrow_mode_a: assert property ( // R14
    @(posedge sys_clk) disable iff (!arst_n)
    (bf_in_valid || rd_req_valid) && addr32_mode |->
      bf_in_data.paddr[63:32] == 32'h0 &&
      (!rd_req_valid || rd_req_addr[63:32] == 32'h0))
    else $error("upper address bits set in 32-bit mode");

  burst_align_a: assert property ( // R03
    @(posedge sys_clk) disable iff (!arst_n)
    rd_req_valid |-> rd_req_addr[5:0] == 6'h00)
    else $error("entry burst not 64-byte aligned");

  table_pick_a: assert property ( // R06
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(rd_req_valid) && !addr32_mode |->
      rd_req_addr[63:12] == tbl_base &&
      rd_req_addr[11:6] == hold.laddr[20:15])
    else $error("wrong table or entry group fetched");

  set_reload_a: assert property ( // R11
    @(posedge sys_clk) disable iff (!arst_n)
    state == ST_CHECK && !hit |=> !tag_valid && rd_req_valid)
    else $error("miss did not start a full reload");

  hit_send_a: assert property ( // R07
    @(posedge sys_clk) disable iff (!arst_n)
    state == ST_CHECK && hit |=> bf_in_valid && !rd_req_valid)
    else $error("hit did not go straight to send");

  fill_eight_a: assert property ( // R15
    @(posedge sys_clk) disable iff (!arst_n)
    rd_req_valid && rd_req_ready ##1 (rd_rsp_valid [*8]) |=>
      tag_valid && bf_in_valid)
    else $error("eight entries did not complete the fill");

  accept_hold_a: assert property ( // R05
    @(posedge sys_clk) disable iff (!arst_n)
    in_valid && in_ready |=>
      state == ST_CHECK && hold == $past(in_pkt) && !in_ready)
    else $error("accepted packet not held");

  req_stable_a: assert property ( // R06
    @(posedge sys_clk) disable iff (!arst_n)
    rd_req_valid && !rd_req_ready |=>
      rd_req_valid && $stable(rd_req_addr))
    else $error("read request dropped or changed while waiting");

  fill_busy_a: assert property ( // R11
    @(posedge sys_clk) disable iff (!arst_n)
    fill_busy == (state == ST_REQ || state == ST_FILL))
    else $error("fill busy flag out of step with the fetch");

  ready_idle_a: assert property ( // R05
    @(posedge sys_clk) disable iff (!arst_n)
    in_ready == (state == ST_IDLE))
    else $error("input ready while a packet is in flight");

  out_hold_a: assert property ( // R16
    @(posedge sys_clk) disable iff (!arst_n)
    out_valid && !out_ready |=>
      out_valid && $stable(out_pkt))
    else $error("stalled output packet dropped or changed");

endmodule

// *** verif/dpt_tb_pkg.sv ***
// Reference contents of host memory shared by bench and memory model
package dpt_tb_pkg;

  // Entry held at a byte address; bits [11:0] are junk the design ignores
  function automatic logic [63:0] entry_of(input logic [63:0] a);
    entry_of = {a[31:0] ^ 32'hC3A5_5A3C, a[31:0] ^ 32'h0F0F_1FFF};
  endfunction

endpackage

// *** verif/dpt_mem_model.sv ***
// Host memory model answering page table burst reads
`timescale 1ns/1ps
module dpt_mem_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic rd_req_valid,
  input wire logic [63:0] rd_req_addr,
  output logic rd_req_ready,
  output logic rd_rsp_valid,
  output logic [63:0] rd_rsp_data,
  output int req_count,
  output logic [63:0] last_addr
);
  logic [63:0] addr;

  // One burst at a time; data toggles while idle and between slow-mode beats so a stray sample
  // of the data lines never looks like a real entry
  initial begin
    rd_req_ready = 1'b0;
    rd_rsp_valid = 1'b0;
    rd_rsp_data = 64'h0;
    req_count = 0;
    last_addr = 64'h0;
    forever begin
      @(posedge sys_clk);
      if (arst_n !== 1'b1 || rd_req_valid !== 1'b1) begin
        rd_rsp_data <= ~rd_rsp_data;
      end else begin
        if (slow) repeat (3) @(posedge sys_clk);
        rd_req_ready <= 1'b1;
        @(posedge sys_clk);
        rd_req_ready <= 1'b0;
        addr = rd_req_addr;
        last_addr <= rd_req_addr;
        req_count <= req_count + 1;
        // Fast mode sends all eight beats back to back after the take
        for (int k = 0; k < 8; k++) begin
          if (slow) begin
            rd_rsp_valid <= 1'b0;
            rd_rsp_data <= ~rd_rsp_data;
            @(posedge sys_clk);
          end
          rd_rsp_valid <= 1'b1;
          rd_rsp_data <= dpt_tb_pkg::entry_of(addr + 64'(8 * k));
          @(posedge sys_clk);
        end
        rd_rsp_valid <= 1'b0;
        rd_rsp_data <= ~rd_rsp_data;
      end
    end
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking testbench of the DMA page table translator
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic arst_n;
  logic in_valid;
  dpt_pkg::dpt_pkt_t in_pkt;
  logic in_ready;
  logic out_valid;
  dpt_pkg::dpt_out_t out_pkt;
  logic out_ready;
  logic cfg_wr;
  logic [3:0] cfg_vchan;
  logic [2:0] cfg_buf;
  logic [51:0] cfg_base;
  logic addr32_mode;
  logic rd_req_valid;
  logic [63:0] rd_req_addr;
  logic rd_req_ready;
  logic rd_rsp_valid;
  logic [63:0] rd_rsp_data;
  logic fill_busy;
  logic slow;
  int req_count;
  logic [63:0] last_addr;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  dpt_translator dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .in_valid(in_valid), .in_pkt(in_pkt), .in_ready(in_ready),
    .out_valid(out_valid), .out_pkt(out_pkt), .out_ready(out_ready),
    .cfg_wr(cfg_wr), .cfg_vchan(cfg_vchan), .cfg_buf(cfg_buf),
    .cfg_base(cfg_base), .addr32_mode(addr32_mode),
    .rd_req_valid(rd_req_valid), .rd_req_addr(rd_req_addr),
    .rd_req_ready(rd_req_ready), .rd_rsp_valid(rd_rsp_valid),
    .rd_rsp_data(rd_rsp_data), .fill_busy(fill_busy));

  dpt_mem_model mem_u (.sys_clk(sys_clk), .arst_n(arst_n), .slow(slow),
    .rd_req_valid(rd_req_valid), .rd_req_addr(rd_req_addr),
    .rd_req_ready(rd_req_ready), .rd_rsp_valid(rd_rsp_valid),
    .rd_rsp_data(rd_rsp_data), .req_count(req_count),
    .last_addr(last_addr));

  // ==========================================================
  // Clock, watchdog and verdict
  always #50 sys_clk = ~sys_clk;

  // A hang anywhere ends the run as a failure
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [130:0] seen, input logic [130:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // Reference mapping
  // Low 12 address bits of every table are zero, so tables sit 4 kB aligned
  function automatic logic [51:0] ptr(input logic [3:0] v,
    input logic [2:0] b);
    ptr = {32'h0000_0A5C, 13'h0, v, b};
  endfunction

  function automatic logic [63:0] exp_req(input dpt_pkg::dpt_pkt_t p);
    exp_req = {ptr(p.vchan, p.laddr[23:21]), p.laddr[20:15], 6'h00};
    if (addr32_mode) exp_req[63:32] = 32'h0;
  endfunction

  function automatic dpt_pkg::dpt_out_t exp_out(input dpt_pkg::dpt_pkt_t p);
    logic [63:0] e;
    e = dpt_tb_pkg::entry_of(exp_req(p) + {58'h0, p.laddr[14:12], 3'h0});
    exp_out.tc = p.tc;
    exp_out.paddr = {e[63:12], p.laddr[11:0]};
    if (addr32_mode) exp_out.paddr[63:32] = 32'h0;
    exp_out.data = p.data;
  endfunction

  // ==========================================================
  // Transfer tasks
  // Offer a packet and hold it until the edge that takes it
  task automatic send(input dpt_pkg::dpt_pkt_t p);
    int n;
    n = 0;
    @(posedge sys_clk);
    in_valid <= 1'b1;
    in_pkt <= p;
    do begin
      @(posedge sys_clk);
      n++;
    end while (in_ready !== 1'b1 && n < 100);
    in_valid <= 1'b0;
    check(n < 100, 1'b1);
  endtask

  // Compare the result at the edge where the sink accepts it
  task automatic recv(input dpt_pkg::dpt_out_t e);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(out_valid === 1'b1 && out_ready === 1'b1) && n < 100);
    check(n < 100, 1'b1);
    check(out_pkt, e);
  endtask

  task automatic xfer(input logic [3:0] v, input logic [31:0] la,
    input logic miss);
    dpt_pkg::dpt_pkt_t p;
    int c0;
    p = {v, v[2:0], la, la, ~la};
    c0 = req_count;
    send(p);
    recv(exp_out(p));
    check(req_count - c0, miss);
    if (miss) check(last_addr, exp_req(p));
  endtask

  // ==========================================================
  // Scenarios
  task automatic reset_values();
    check({in_ready, out_valid, rd_req_valid, fill_busy}, 4'h8);
    check(rd_req_addr, 64'h0);
    check(out_pkt, 131'h0);
  endtask

  // Every channel gets all eight buffers, well above the minimum of two
  task automatic load_pointers();
    for (int i = 0; i < 128; i++) begin
      @(posedge sys_clk);
      cfg_wr <= 1'b1;
      cfg_vchan <= i[6:3];
      cfg_buf <= i[2:0];
      cfg_base <= ptr(i[6:3], i[2:0]);
    end
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask

  task automatic hit_and_miss();
    xfer(4'h0, 32'h0000_5ABC, 1'b1);
    xfer(4'h0, 32'h0000_6123, 1'b0);
    xfer(4'h0, 32'h0000_8FFF, 1'b1);
    xfer(4'h3, 32'h0000_0001, 1'b1);
    xfer(4'h3, 32'h0000_7002, 1'b0);
  endtask

  // Each step changes channel or buffer, top byte is junk to be ignored
  task automatic chan_buf_sweep();
    for (int i = 0; i < 128; i++) begin
      xfer(i[6:3], {8'hA5, i[2:0], i[6:0], 2'h3, i[11:0]}, 1'b1);
    end
  endtask

  task automatic narrow_addr();
    @(posedge sys_clk);
    addr32_mode <= 1'b1;
    xfer(4'hF, 32'h00C4_0800, 1'b1);
    xfer(4'hF, 32'h00C4_1FFC, 1'b0);
    @(posedge sys_clk);
    addr32_mode <= 1'b0;
  endtask

  // Sink stalls through a slow fill, then six more cycles with the buffer full
  task automatic stall();
    dpt_pkg::dpt_pkt_t p [3];
    p[0] = {4'h7, 3'h1, 32'h0044_1010, 64'h1111};
    p[1] = {4'h7, 3'h2, 32'h0044_2020, 64'h2222};
    p[2] = {4'h7, 3'h3, 32'h0044_3030, 64'h3333};
    @(posedge sys_clk);
    slow <= 1'b1;
    out_ready <= 1'b0;
    for (int i = 0; i < 3; i++) send(p[i]);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      check({out_valid, in_ready, fill_busy}, 3'h4);
      check(out_pkt, exp_out(p[0]));
    end
    out_ready <= 1'b1;
    for (int i = 0; i < 3; i++) recv(exp_out(p[i]));
    slow <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    in_valid = 1'b0;
    in_pkt = '0;
    out_ready = 1'b1;
    cfg_wr = 1'b0;
    cfg_vchan = 4'h0;
    cfg_buf = 3'h0;
    cfg_base = 52'h0;
    addr32_mode = 1'b0;
    slow = 1'b0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    reset_values();
    load_pointers();
    hit_and_miss();
    chan_buf_sweep();
    narrow_addr();
    stall();
    report_and_stop();
  end
endmodule
